// file: hw/dsx_consts.svh
`ifndef DSX_CONSTS_SVH
`define DSX_CONSTS_SVH

// Data-space map
`define DSX_IO_DATA_OFFSET 16'h0020
`define DSX_IO_LAST 16'h005F
`define DSX_BITIO_LAST 6'h1F
`define DSX_EXTIO_LAST 16'h00FF
`define DSX_RAM_END_NORMAL 16'h10FF
`define DSX_RAM_END_COMPAT 16'h0FFF

// Locations of the block's own registers (data-space addresses)
`define DSX_FLAG_ADDR 16'h0038
`define DSX_CTRL_A_ADDR 16'h0075
`define DSX_CTRL_B_ADDR 16'h0074

// Reset values and writable-bit masks
`define DSX_CTRL_A_RST 8'h00
`define DSX_CTRL_B_RST 8'h00
`define DSX_FLAG_RST 8'h00
`define DSX_CTRL_A_WMASK 8'h7F
`define DSX_CTRL_B_WMASK 8'h87

// Field positions of ext_bus_control_a
`define DSX_CA_SECTOR_HI 6
`define DSX_CA_SECTOR_LO 4
`define DSX_CA_LOWER_HI 3
`define DSX_CA_LOWER_LO 2
`define DSX_CA_UPPER_BIT 1
`define DSX_SECTOR_ZERO 13'h0000

// Field positions of ext_bus_control_b
`define DSX_CB_KEEPER_BIT 7
`define DSX_CB_RELEASE_HI 2
`define DSX_CB_RELEASE_LO 0

// Timing and pin counts
`define DSX_WAIT_NONE 2'h0
`define DSX_HI_PINS 4'h8

`endif

// file: hw/dsx_pkg.sv
package dsx_pkg;

    typedef enum logic [4:0]
    {
        ST_IDLE = 5'b00001,
        ST_IO_RD = 5'b00010,
        ST_SRAM = 5'b00100,
        ST_EXT_ALE = 5'b01000,
        ST_EXT_STRB = 5'b10000
    } dsx_state_type;

    typedef enum logic [2:0]
    {
        OP_LOAD = 3'h0,
        OP_STORE = 3'h1,
        OP_IN = 3'h2,
        OP_OUT = 3'h3,
        OP_SETBIT = 3'h4,
        OP_CLRBIT = 3'h5,
        OP_SKIPSET = 3'h6,
        OP_SKIPCLR = 3'h7
    } dsx_op_type;

endpackage

// file: hw/dsx_io_mem.sv
`timescale 1ns/100ps
`default_nettype none

module dsx_io_mem
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic we_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);

    logic [7:0] mem [0:255];

    // Storage array, no reset on the cells
    always_ff @(posedge sys_clk_i)
    begin
        if (we_i)
        begin
            mem[addr_i] <= wdata_i;
        end
    end

    // Registered read port
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_o <= 8'h00;
        end
        else
        begin
            rdata_o <= mem[addr_i];
        end
    end

endmodule

`default_nettype wire

// file: hw/dsx_data_bus.sv
// How it works
// R01 - Every I/O location answers ordinary data-space loads and stores.
// R02 - I/O addresses $00-$1F accept single-bit set and clear.
// R03 - Same range supports skip-if-bit-set and skip-if-bit-clear tests.
// R04 - IN and OUT use I/O addresses $00 to $3F.
// R05 - Data-space address of an I/O register is its I/O address plus $20.
// R06 - Extended I/O $60-$FF reachable only by data-space loads and stores.
// R07 - In legacy mode extended I/O addresses become ordinary SRAM.
// R08 - Some flags clear on writing one; writing zero leaves them.
// R09 - Bit set and clear rewrite the whole register, clearing set flags.
// R10 - Software writes reserved bits as zero, avoids reserved addresses.
// R11 - Four wait-state settings for external accesses, one with none.
// R12 - External space splits into sectors, each with its own wait setting.
// R13 - Number of high address pins is selectable; unused pins released.
// R14 - Optional bus-keepers hold the data lines' last level.
// R15 - With interface enabled, addresses above internal SRAM go to pins.
// R16 - Both control registers sit in extended I/O; hidden and off in legacy.
// R17 - Legacy mode offers only upper wait encodings 0b00 and 0b01.
// R18 - Legacy mode fixes the count of high address pins.
// R19 - Legacy mode uses one wait setting, no sectors.
// R20 - Legacy mode has no bus-keeper.
// R21 - Legacy mode makes read, write and latch strobes outputs only.
// R22 - Low address valid when latch strobe falls; strobe low during data.
// R23 - Internal accesses may move address, data, latch; never the strobes.
// R24 - External access costs one cycle more, plus one per wait state.
// R25 - Each access is routed internal or external automatically.
// R26 - After reset the external interface is off and pins are released.
`timescale 1ns/100ps
`default_nettype none
`include "dsx_consts.svh"

module dsx_data_bus
    import dsx_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic req_i,
    input wire logic [2:0] op_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [2:0] bit_i,
    input wire logic compat_mode_i,
    input wire logic external_memory_interface_enable_i,
    input wire logic upper_wait_lo_i,
    input wire logic [7:0] flag_set_i,
    input wire logic [7:0] sram_rdata_i,
    input wire logic [7:0] ad_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic skip_o,
    output logic err_o,
    output logic [7:0] flags_o,
    output logic sram_req_o,
    output logic sram_we_o,
    output logic [15:0] sram_addr_o,
    output logic [7:0] sram_wdata_o,
    output logic external_memory_interface_en_o,
    output logic [7:0] ad_o,
    output logic ad_oe_n_o,
    output logic [7:0] addr_hi_o,
    output logic [7:0] addr_hi_oe_n_o,
    output logic ale_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic keeper_en_o,
    output logic strobe_out_only_o
);

    dsx_state_type state, next_state;
    dsx_op_type op_q, next_op_q;
    logic [15:0] addr_q, next_addr_q;
    logic [7:0] wdata_q, next_wdata_q;
    logic [2:0] bit_q, next_bit_q;
    logic [1:0] wcnt, next_wcnt;
    logic [7:0] ctrl_a, next_ctrl_a;
    logic [7:0] ctrl_b, next_ctrl_b;
    logic [7:0] next_flags, flag_clr;
    logic next_busy, next_done, next_skip, next_err;
    logic [7:0] next_rdata;
    logic next_sram_req, next_sram_we;
    logic [15:0] next_sram_addr;
    logic [7:0] next_sram_wdata;
    logic [7:0] next_ad, next_addr_hi;
    logic next_ad_oe_n, next_ale, next_rd_n, next_wr_n;
    logic [7:0] hi_used;
    logic [7:0] mem_rdata, mem_wdata, mem_addr;
    logic mem_we;
    logic take, req_bitop, req_io_op, ext_en;
    logic [15:0] req_daddr, ram_end, sector_bound;
    logic [1:0] upper_wait, lower_wait, ext_wait;
    logic [7:0] io_rval, io_wval, bit_mask;
    logic io_write, hit_flag, hit_ca, hit_cb;

    // Request decode: I/O addresses shift up by $20 into data space
    assign take = (state == ST_IDLE) && req_i;
    assign req_bitop = op_i[2];
    assign req_io_op = (op_i != OP_LOAD) && (op_i != OP_STORE);
    assign req_daddr = req_io_op ?
        ({10'h000, addr_i[5:0]} + `DSX_IO_DATA_OFFSET) : addr_i; // R05 R04
    assign ram_end = compat_mode_i ? `DSX_RAM_END_COMPAT :
        `DSX_RAM_END_NORMAL;
    assign ext_en = external_memory_interface_en_o;

    // Wait-state selection per sector; legacy keeps one upper setting
    assign upper_wait = {ctrl_a[`DSX_CA_UPPER_BIT] & ~compat_mode_i,
        upper_wait_lo_i}; // R17
    assign lower_wait = ctrl_a[`DSX_CA_LOWER_HI:`DSX_CA_LOWER_LO];
    assign sector_bound = {ctrl_a[`DSX_CA_SECTOR_HI:`DSX_CA_SECTOR_LO],
        `DSX_SECTOR_ZERO};
    assign ext_wait = (compat_mode_i || sector_bound == 16'h0000) ?
        upper_wait : // R19
        ((req_daddr < sector_bound) ? lower_wait : upper_wait); // R12 R11

    // Register read mux and read-modify-write value
    assign hit_flag = addr_q == `DSX_FLAG_ADDR;
    assign hit_ca = !compat_mode_i && addr_q == `DSX_CTRL_A_ADDR; // R16
    assign hit_cb = !compat_mode_i && addr_q == `DSX_CTRL_B_ADDR; // R16
    assign io_rval = hit_flag ? flags_o : hit_ca ? ctrl_a :
        hit_cb ? ctrl_b : mem_rdata; // R01
    assign bit_mask = 8'h01 << bit_q;
    assign io_write = (op_q == OP_STORE) || (op_q == OP_OUT) ||
        (op_q == OP_SETBIT) || (op_q == OP_CLRBIT);
    assign io_wval = (op_q == OP_SETBIT) ? (io_rval | bit_mask) : // R02 R09
        (op_q == OP_CLRBIT) ? (io_rval & ~bit_mask) : wdata_q;
    assign mem_we = (state == ST_IO_RD) && io_write && !hit_flag &&
        !hit_ca && !hit_cb;
    assign mem_addr = (state == ST_IDLE) ? req_daddr[7:0] : addr_q[7:0];
    assign mem_wdata = io_wval;

    // High address pins in use, top ones released by the field
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_hi
            assign hi_used[gi] = compat_mode_i || // R18
                ({1'b0, ctrl_b[`DSX_CB_RELEASE_HI:`DSX_CB_RELEASE_LO]} <
                (`DSX_HI_PINS - 4'(gi))); // R13
        end
    endgenerate

    dsx_io_mem u_io_mem
    (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .we_i(mem_we),
        .addr_i(mem_addr),
        .wdata_i(mem_wdata),
        .rdata_o(mem_rdata)
    );

    // Access sequencer, register updates and pin timing
    always_comb
    begin
        next_state = state;
        next_op_q = op_q;
        next_addr_q = addr_q;
        next_wdata_q = wdata_q;
        next_bit_q = bit_q;
        next_wcnt = wcnt;
        next_ctrl_a = ctrl_a;
        next_ctrl_b = ctrl_b;
        flag_clr = 8'h00;
        next_done = 1'b0;
        next_skip = 1'b0;
        next_err = 1'b0;
        next_rdata = rdata_o;
        next_sram_req = 1'b0;
        next_sram_we = sram_we_o;
        next_sram_addr = sram_addr_o;
        next_sram_wdata = sram_wdata_o;
        next_ad = ad_o;
        next_addr_hi = addr_hi_o;
        next_ad_oe_n = ad_oe_n_o;
        next_ale = 1'b0;
        next_rd_n = 1'b1;
        next_wr_n = 1'b1;
        unique case (state)
            ST_IDLE:
            begin
                if (take)
                begin
                    next_op_q = dsx_op_type'(op_i);
                    next_addr_q = req_daddr;
                    next_wdata_q = wdata_i;
                    next_bit_q = bit_i;
                    next_wcnt = ext_wait;
                    if (ext_en)
                    begin
                        // Address shows for every access while enabled
                        next_ale = 1'b1; // R22 R23
                        next_ad = req_daddr[7:0];
                        next_ad_oe_n = 1'b0;
                        next_addr_hi = req_daddr[15:8];
                    end
                    if ((req_bitop && addr_i[5:0] > `DSX_BITIO_LAST) ||
                        req_daddr < `DSX_IO_DATA_OFFSET)
                    begin
                        next_done = 1'b1; // R02 R03
                        next_err = 1'b1;
                        next_rdata = 8'h00;
                    end
                    else if (req_daddr <= `DSX_IO_LAST ||
                        (req_daddr <= `DSX_EXTIO_LAST && !compat_mode_i))
                    begin
                        next_state = ST_IO_RD; // R01 R06
                    end
                    else if (req_daddr <= ram_end)
                    begin
                        next_state = ST_SRAM; // R07 R25
                        next_sram_req = 1'b1;
                        next_sram_we = op_i == OP_STORE;
                        next_sram_addr = req_daddr;
                        next_sram_wdata = wdata_i;
                    end
                    else if (ext_en)
                    begin
                        next_state = ST_EXT_ALE; // R15 R25
                    end
                    else
                    begin
                        next_done = 1'b1;
                        next_rdata = 8'h00;
                    end
                end
            end
            ST_IO_RD:
            begin
                next_state = ST_IDLE;
                next_done = 1'b1;
                next_rdata = io_rval;
                next_ad_oe_n = 1'b1;
                if (op_q == OP_SKIPSET)
                begin
                    next_skip = |(io_rval & bit_mask); // R03
                end
                if (op_q == OP_SKIPCLR)
                begin
                    next_skip = ~|(io_rval & bit_mask); // R03
                end
                if (io_write && hit_flag)
                begin
                    flag_clr = io_wval; // R08 R09
                end
                if (io_write && hit_ca)
                begin
                    next_ctrl_a = io_wval & `DSX_CTRL_A_WMASK;
                end
                if (io_write && hit_cb)
                begin
                    next_ctrl_b = io_wval & `DSX_CTRL_B_WMASK;
                end
            end
            ST_SRAM:
            begin
                // Strobes stay high on internal accesses
                next_state = ST_IDLE; // R23
                next_done = 1'b1;
                next_rdata = sram_rdata_i;
                next_ad_oe_n = 1'b1;
            end
            ST_EXT_ALE:
            begin
                // Latch strobe falls with address still held
                next_state = ST_EXT_STRB; // R22
                if (op_q == OP_STORE)
                begin
                    next_ad = wdata_q;
                    next_wr_n = 1'b0;
                end
                else
                begin
                    next_ad_oe_n = 1'b1;
                    next_rd_n = 1'b0;
                end
            end
            ST_EXT_STRB:
            begin
                if (wcnt == `DSX_WAIT_NONE)
                begin
                    next_state = ST_IDLE; // R24
                    next_done = 1'b1;
                    next_ad_oe_n = 1'b1;
                    if (op_q != OP_STORE)
                    begin
                        next_rdata = ad_i;
                    end
                end
                else
                begin
                    next_wcnt = wcnt - 2'h1; // R11 R24
                    next_rd_n = rd_n_o;
                    next_wr_n = wr_n_o;
                end
            end
        endcase
        if (compat_mode_i)
        begin
            next_ctrl_a = `DSX_CTRL_A_RST; // R16
            next_ctrl_b = `DSX_CTRL_B_RST;
        end
        if (!ext_en)
        begin
            next_ad_oe_n = 1'b1; // R26
            next_rd_n = 1'b1;
            next_wr_n = 1'b1;
            next_ale = 1'b0;
        end
        // Hardware set wins over a software clear
        next_flags = (flags_o & ~flag_clr) | flag_set_i; // R08
        next_busy = next_state != ST_IDLE;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state <= ST_IDLE;
            op_q <= OP_LOAD;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
            bit_q <= 3'h0;
            wcnt <= 2'h0;
            ctrl_a <= `DSX_CTRL_A_RST;
            ctrl_b <= `DSX_CTRL_B_RST;
            flags_o <= `DSX_FLAG_RST;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= 8'h00;
            skip_o <= 1'b0;
            err_o <= 1'b0;
            sram_req_o <= 1'b0;
            sram_we_o <= 1'b0;
            sram_addr_o <= 16'h0000;
            sram_wdata_o <= 8'h00;
            external_memory_interface_en_o <= 1'b0;
            ad_o <= 8'h00;
            ad_oe_n_o <= 1'b1;
            addr_hi_o <= 8'h00;
            addr_hi_oe_n_o <= 8'hFF;
            ale_o <= 1'b0;
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            keeper_en_o <= 1'b0;
            strobe_out_only_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            op_q <= next_op_q;
            addr_q <= next_addr_q;
            wdata_q <= next_wdata_q;
            bit_q <= next_bit_q;
            wcnt <= next_wcnt;
            ctrl_a <= next_ctrl_a;
            ctrl_b <= next_ctrl_b;
            flags_o <= next_flags;
            busy_o <= next_busy;
            done_o <= next_done;
            rdata_o <= next_rdata;
            skip_o <= next_skip;
            err_o <= next_err;
            sram_req_o <= next_sram_req;
            sram_we_o <= next_sram_we;
            sram_addr_o <= next_sram_addr;
            sram_wdata_o <= next_sram_wdata;
            external_memory_interface_en_o <= external_memory_interface_enable_i; // R26
            ad_o <= next_ad;
            ad_oe_n_o <= next_ad_oe_n;
            addr_hi_o <= next_addr_hi;
            addr_hi_oe_n_o <= ~(hi_used & {8{ext_en}}); // R13
            ale_o <= next_ale;
            rd_n_o <= next_rd_n;
            wr_n_o <= next_wr_n;
            keeper_en_o <= ext_en && ctrl_b[`DSX_CB_KEEPER_BIT] &&
                !compat_mode_i; // R14 R20
            strobe_out_only_o <= compat_mode_i; // R21
        end
    end

    property p_io_offset;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        take && op_i == OP_IN |=> state == ST_IO_RD &&
            addr_q == {10'h000, $past(addr_i[5:0])} + 16'h0020 ##1 done_o;
    endproperty
    a_io_offset: assert property (p_io_offset) // R05
        else $error("IN address not mapped at plus 20 hex");

    property p_bit_range;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        take && req_bitop && addr_i[5] |=> err_o && done_o;
    endproperty
    a_bit_range: assert property (p_bit_range) // R02
        else $error("bit access above 1F hex not refused");

    property p_extio_compat;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        take && compat_mode_i && op_i == OP_LOAD &&
            addr_i >= 16'h0060 && addr_i <= 16'h00FF |=> sram_req_o;
    endproperty
    a_extio_compat: assert property (p_extio_compat) // R07
        else $error("legacy extended I/O not sent to SRAM");

    property p_flag_set_wins;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        flag_set_i[0] |=> flags_o[0];
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins) // R08
        else $error("flag event lost");

    property p_no_strobe_internal;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        state == ST_SRAM || state == ST_IO_RD |-> rd_n_o && wr_n_o;
    endproperty
    a_no_strobe_internal: assert property (p_no_strobe_internal) // R23
        else $error("strobe toggled on internal access");

    property p_ale_then_strobe;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        take && next_state == ST_EXT_ALE |=> ale_o && !ad_oe_n_o
            ##1 !ale_o && (!rd_n_o || !wr_n_o);
    endproperty
    a_ale_then_strobe: assert property (p_ale_then_strobe) // R22
        else $error("latch strobe and data phase out of order");

    property p_ext_nowait;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        take && next_state == ST_EXT_ALE && ext_wait == 2'h0
            |-> ##2 !done_o ##1 done_o;
    endproperty
    a_ext_nowait: assert property (p_ext_nowait) // R24
        else $error("external access latency wrong");

    property p_keeper_compat;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        compat_mode_i |=> !keeper_en_o;
    endproperty
    a_keeper_compat: assert property (p_keeper_compat) // R20
        else $error("bus keeper on in legacy mode");

    property p_disabled_idle;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !external_memory_interface_en_o |=> ad_oe_n_o && rd_n_o && wr_n_o && !ale_o;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) // R26
        else $error("pins driven with interface disabled");

    property p_compat_wait;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        take && compat_mode_i |=> wcnt <= 2'h1;
    endproperty
    a_compat_wait: assert property (p_compat_wait) // R17
        else $error("legacy wait above one");

endmodule

`default_nettype wire

// file: test/dsx_ext_mem.sv
`timescale 1ns/100ps
`default_nettype none

// External byte memory behind the latched muxed address/data lines
module dsx_ext_mem
(
    input wire logic sys_clk_i,
    input wire logic ale_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [7:0] bus_i,
    output logic [7:0] drv_o
);
    logic [7:0] mem [0:255];
    logic [7:0] lo = 8'h00;
    logic [7:0] last = 8'h00;

    // Latch the low address under the strobe, store under write
    always @(posedge sys_clk_i)
    begin
        if (ale_i)
            lo <= bus_i;
        if (!wr_n_i)
            mem[lo] <= bus_i;
        if (!rd_n_i)
            last <= mem[lo];
    end

    // Drive only under read strobe; released lines show the inverse
    assign drv_o = !rd_n_i ? mem[lo] : ~last;
endmodule

`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import dsx_pkg::*;
    // Request, mode {legacy, enable, wait low}, expected data/skip-err/cycles
    typedef struct packed
    {
        logic [2:0] op; logic [15:0] a; logic [7:0] d; logic [2:0] b;
        logic [2:0] m; logic [7:0] r; logic [1:0] se; logic [3:0] lt;
    } dsx_row_type;
    logic sys_clk_i, resetn_i, req_i, compat_mode_i, external_memory_interface_enable_i;
    logic upper_wait_lo_i, busy_o, done_o, skip_o, err_o, sram_req_o;
    logic sram_we_o, external_memory_interface_en_o, ad_oe_n_o, ale_o, rd_n_o, wr_n_o;
    logic keeper_en_o, strobe_out_only_o, got_sk, got_er, got_b;
    logic [2:0] op_i, bit_i;
    logic [15:0] addr_i, sram_addr_o;
    logic [7:0] wdata_i, flag_set_i, sram_rdata_i, ad_i, rdata_o, flags_o;
    logic [7:0] sram_wdata_o, ad_o, addr_hi_o, addr_hi_oe_n_o, mem_drv, got_r;
    logic [3:0] lat, strb, es;
    int num_errors = 0;
    int compares = 0;
    dsx_row_type rows [30] = '{
        '{OP_OUT,16'h0005,8'hA5,3'h0,3'h2,8'h00,2'h0,4'h1},
        '{OP_LOAD,16'h0025,8'h00,3'h0,3'h2,8'hA5,2'h0,4'h1},
        '{OP_OUT,16'h003F,8'h77,3'h0,3'h2,8'h00,2'h0,4'h1},
        '{OP_LOAD,16'h005F,8'h00,3'h0,3'h2,8'h77,2'h0,4'h1},
        '{OP_STORE,16'h0060,8'h3C,3'h0,3'h2,8'h00,2'h0,4'h1},
        '{OP_LOAD,16'h0060,8'h00,3'h0,3'h2,8'h3C,2'h0,4'h1},
        '{OP_SETBIT,16'h0005,8'h00,3'h1,3'h2,8'h00,2'h0,4'h1},
        '{OP_IN,16'h0005,8'h00,3'h0,3'h2,8'hA7,2'h0,4'h1},
        '{OP_CLRBIT,16'h0005,8'h00,3'h0,3'h2,8'h00,2'h0,4'h1},
        '{OP_IN,16'h0005,8'h00,3'h0,3'h2,8'hA6,2'h0,4'h1},
        '{OP_SKIPSET,16'h0005,8'h00,3'h1,3'h2,8'h00,2'h2,4'h1},
        '{OP_SKIPCLR,16'h0005,8'h00,3'h0,3'h2,8'h00,2'h2,4'h1},
        '{OP_SKIPSET,16'h0005,8'h00,3'h0,3'h2,8'h00,2'h0,4'h1},
        '{OP_SETBIT,16'h0020,8'h00,3'h0,3'h2,8'h00,2'h1,4'h0},
        '{OP_LOAD,16'h0010,8'h00,3'h0,3'h2,8'h00,2'h1,4'h0},
        '{OP_LOAD,16'h0025,8'h00,3'h0,3'h0,8'hA6,2'h0,4'h1},
        '{OP_LOAD,16'h2000,8'h00,3'h0,3'h0,8'h00,2'h0,4'h0},
        '{OP_LOAD,16'h1000,8'h00,3'h0,3'h2,8'h5A,2'h0,4'h1},
        '{OP_STORE,16'h2000,8'h99,3'h0,3'h2,8'h00,2'h0,4'h2},
        '{OP_LOAD,16'h2000,8'h00,3'h0,3'h2,8'h99,2'h0,4'h2},
        '{OP_LOAD,16'h2000,8'h00,3'h0,3'h3,8'h99,2'h0,4'h3},
        '{OP_STORE,16'h0075,8'h0E,3'h0,3'h2,8'h00,2'h0,4'h1},
        '{OP_LOAD,16'h0075,8'h00,3'h0,3'h2,8'h0E,2'h0,4'h1},
        '{OP_LOAD,16'h2000,8'h00,3'h0,3'h3,8'h99,2'h0,4'h5},
        '{OP_STORE,16'h0075,8'h4E,3'h0,3'h2,8'h00,2'h0,4'h1},
        '{OP_LOAD,16'h2000,8'h00,3'h0,3'h2,8'h99,2'h0,4'h5},
        '{OP_LOAD,16'h8000,8'h00,3'h0,3'h2,8'h99,2'h0,4'h4},
        '{OP_LOAD,16'h0075,8'h00,3'h0,3'h6,8'h2F,2'h0,4'h1},
        '{OP_LOAD,16'h1000,8'h00,3'h0,3'h7,8'h99,2'h0,4'h3},
        '{OP_LOAD,16'h0060,8'h00,3'h0,3'h6,8'h3A,2'h0,4'h1}
    };

    dsx_data_bus i_dut
    (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .req_i(req_i),
        .op_i(op_i), .addr_i(addr_i), .wdata_i(wdata_i), .bit_i(bit_i),
        .compat_mode_i(compat_mode_i), .external_memory_interface_enable_i(external_memory_interface_enable_i),
        .upper_wait_lo_i(upper_wait_lo_i), .flag_set_i(flag_set_i),
        .sram_rdata_i(sram_rdata_i), .ad_i(ad_i), .busy_o(busy_o),
        .done_o(done_o), .rdata_o(rdata_o), .skip_o(skip_o), .err_o(err_o),
        .flags_o(flags_o), .sram_req_o(sram_req_o), .sram_we_o(sram_we_o),
        .sram_addr_o(sram_addr_o), .sram_wdata_o(sram_wdata_o),
        .external_memory_interface_en_o(external_memory_interface_en_o), .ad_o(ad_o), .ad_oe_n_o(ad_oe_n_o),
        .addr_hi_o(addr_hi_o), .addr_hi_oe_n_o(addr_hi_oe_n_o),
        .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
        .keeper_en_o(keeper_en_o), .strobe_out_only_o(strobe_out_only_o)
    );

    dsx_ext_mem i_mem
    (
        .sys_clk_i(sys_clk_i), .ale_i(ale_o), .rd_n_i(rd_n_o),
        .wr_n_i(wr_n_o), .bus_i(ad_i), .drv_o(mem_drv)
    );

    // Wire level of the muxed lines; internal SRAM answers address xor 5A
    assign ad_i = !ad_oe_n_o ? ad_o : mem_drv;
    assign sram_rdata_i = sram_addr_o[7:0] ^ 8'h5A;

    // System clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input string n, input logic [7:0] s,
        input logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    function automatic dsx_row_type mk(input logic [2:0] op,
        input logic [15:0] a, input logic [7:0] d);
        mk = '{op, a, d, 3'h0, 3'h2, 8'h00, 2'h0, 4'h0};
    endfunction

    // One access: count cycles to done and strobe-low cycles
    task automatic acc(input dsx_row_type t);
        {compat_mode_i, external_memory_interface_enable_i, upper_wait_lo_i} = t.m;
        op_i = t.op;
        addr_i = t.a;
        wdata_i = t.d;
        bit_i = t.b;
        req_i = 1'b1;
        @(posedge sys_clk_i);
        #10 req_i = 1'b0;
        got_b = busy_o;
        lat = 4'h0;
        strb = 4'h0;
        while (done_o !== 1'b1 && lat < 4'hC)
        begin
            @(posedge sys_clk_i);
            #10 lat++;
            if (rd_n_o === 1'b0 || wr_n_o === 1'b0)
                strb++;
        end
        {got_r, got_sk, got_er} = {rdata_o, skip_o, err_o};
        @(posedge sys_clk_i);
        #10;
    endtask

    task automatic end_sim;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        #400000;
        num_errors++;
        end_sim();
    end

    // Table of accesses, then flags, bus options and reset
    initial
    begin
        {req_i, compat_mode_i, upper_wait_lo_i, op_i, bit_i} = 9'h000;
        {addr_i, wdata_i, flag_set_i} = 32'h00000000;
        external_memory_interface_enable_i = 1'b1;
        resetn_i = 1'b0;
        repeat (4) @(posedge sys_clk_i);
        #10 resetn_i = 1'b1;
        @(posedge sys_clk_i);
        #10;
        foreach (rows[i])
        begin
            acc(rows[i]);
            es = rows[i].lt > 4'h1 ? rows[i].lt - 4'h1 : 4'h0;
            chk("cycles", {4'h0, lat}, {4'h0, rows[i].lt});
            chk("strobes", {4'h0, strb}, {4'h0, es});
            chk("sk_er", {6'h00, got_sk, got_er}, {6'h00, rows[i].se});
            chk("busy", {7'h00, got_b}, {7'h00, rows[i].lt != 4'h0});
            if (rows[i].op == OP_LOAD || rows[i].op == OP_IN)
                chk("rdata", got_r, rows[i].r);
            $display("row %0d done", i);
        end
        flag_set_i = 8'h24;
        @(posedge sys_clk_i);
        #10 flag_set_i = 8'h00;
        chk("flags", flags_o, 8'h24);
        acc(mk(OP_STORE, 16'h0038, 8'h04));
        chk("flags", flags_o, 8'h20);
        acc(mk(OP_SETBIT, 16'h0018, 8'h00));
        chk("flags", flags_o, 8'h00);
        // Internal SRAM store shows its address on the high pins too
        acc(mk(OP_STORE, 16'h0A34, 8'h6C));
        chk("sram_we", {7'h00, sram_we_o}, 8'h01);
        chk("sram_ahi", sram_addr_o[15:8], 8'h0A);
        chk("sram_alo", sram_addr_o[7:0], 8'h34);
        chk("sram_d", sram_wdata_o, 8'h6C);
        chk("addr_hi", addr_hi_o, 8'h0A);
        $display("flag test done");
        acc(mk(OP_STORE, 16'h0074, 8'h83));
        chk("keeper", {7'h00, keeper_en_o}, 8'h01);
        chk("hi_oe", addr_hi_oe_n_o, 8'hE0);
        compat_mode_i = 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #10;
        chk("keeper", {7'h00, keeper_en_o}, 8'h00);
        chk("hi_oe", addr_hi_oe_n_o, 8'h00);
        chk("out_only", {7'h00, strobe_out_only_o}, 8'h01);
        compat_mode_i = 1'b0;
        acc(mk(OP_STORE, 16'h0074, 8'h80));
        chk("keeper", {7'h00, keeper_en_o}, 8'h01);
        $display("bus option test done");
        resetn_i = 1'b0;
        #10;
        chk("pin", {4'h0, external_memory_interface_en_o, ad_oe_n_o, rd_n_o, wr_n_o}, 8'h07);
        chk("hi_oe", addr_hi_oe_n_o, 8'hFF);
        @(posedge sys_clk_i);
        #10 resetn_i = 1'b1;
        @(posedge sys_clk_i);
        #10;
        chk("enable", {7'h00, external_memory_interface_en_o}, 8'h01);
        acc(mk(OP_LOAD, 16'h0074, 8'h00));
        chk("ctrl_b", got_r, 8'h00);
        $display("reset test done");
        end_sim();
    end
endmodule

`default_nettype wire
